// ### rtl/lpb_br_cond.sv
// Purpose: branch condition evaluation on the condition codes
// Assumes: op_in is a latched opcode
// Notes:   purely combinational
`timescale 1ns/1ps
module lpb_br_cond
  import lpb_pkg::*;
(
  input  wire logic [7:0] op_in,
  input  wire logic [7:0] ccr_in,
  output logic            take_out
);
  logic nv;

  assign nv = ccr_in[CCR_N] ^ ccr_in[CCR_V];

  always_comb begin
    case (op_in)
      OP_BCC:  take_out = !ccr_in[CCR_C];
      OP_BCS:  take_out = ccr_in[CCR_C];
      OP_BRANCH_HALF_CARRY_CLEAR: take_out = !ccr_in[CCR_H];
      OP_BRANCH_HALF_CARRY_SET: take_out = ccr_in[CCR_H];
      OP_BGE:  take_out = !nv;
      OP_BGT:  take_out = !(ccr_in[CCR_Z] | nv);
      default: take_out = 1'b0;
    endcase
  end
endmodule : lpb_br_cond

// ### rtl/lpb_core.sv
// Purpose: standby, break and branch/immediate-add control of the core
// Assumes: memory read data stand one cycle after mem_rd_out
// Notes:   one level of interrupt context is kept in shadow registers
//
// The placing of the registers and strobed register access are this design's own decisions.
`timescale 1ns/1ps
module lpb_core
  import lpb_pkg::*;
(
  input  wire logic        clock_in,
  input  wire logic        rst_in,
  input  wire logic [7:0]  mem_rdata_in,
  input  wire logic        irq_in,
  input  wire logic        ext_irq_in,
  input  wire logic [15:0] irq_vec_in,
  input  wire logic        brk_req_in,
  input  wire logic [7:0]  reg_addr_in,
  input  wire logic [31:0] reg_wdata_in,
  input  wire logic        reg_wr_in,
  input  wire logic        reg_rd_in,
  output logic [15:0]      mem_addr_out,
  output logic             mem_rd_out,
  output logic             cpu_clk_en_out,
  output logic             irq_ack_out,
  output logic             brk_active_out,
  output logic [31:0]      reg_rdata_out
);
  //--------------------------------------------------------------------
  // State
  //--------------------------------------------------------------------
  lpb_state_t  state_q;
  logic [7:0]  ir_q;
  logic [15:0] pc_q;
  logic [15:0] sp_q;
  logic [15:0] hx_q;
  logic [7:0]  ccr_q;
  logic [15:0] vaddr_q;
  logic [7:0]  vhi_q;
  logic [15:0] sh_pc_q;
  logic [7:0]  sh_ccr_q;
  logic        brk_pend_q;
  logic        brk_act_q;
  logic        xpend_q;
  logic        xsp_q;
  logic [1:0]  ctrl_q;
  logic        irq_ack_q;
  logic [31:0] rdata_q;

  logic [7:0]  op;
  logic        opnd;
  logic        is_br;
  logic        is_imm;
  logic        stop_ok;
  logic        bound;
  logic        go_brk;
  logic        go_irq;
  logic        take;
  logic        stab_done;
  logic        stab_start;
  logic [15:0] pc_d;
  logic [7:0]  ccr_d;

  assign op      = mem_rdata_in;
  assign opnd    = state_q == S_OPND;
  assign is_br   = lpb_is_branch(op);
  assign is_imm  = op == OP_AIS || op == OP_AIX;
  assign stop_ok = ctrl_q[CTRL_STOPEN];

  // Last cycle of an instruction: break or interrupt may start here
  assign bound = (opnd && !is_br && op != OP_WAIT &&
                  !(op == OP_STOP && stop_ok)) || state_q == S_BRANCH;
  assign go_brk = bound && (brk_pend_q || brk_req_in) && !brk_act_q;
  assign go_irq = (bound && !go_brk && irq_in && !ccr_d[CCR_I])
               || (state_q == S_WAIT && irq_in)
               || (state_q == S_STAB && stab_done);
  assign stab_start = state_q == S_STOP && irq_in && ext_irq_in;

  lpb_br_cond u_cond (
    .op_in    (ir_q),
    .ccr_in   (ccr_q),
    .take_out (take)
  );

  lpb_stab_timer u_stab (
    .clock_in (clock_in),
    .rst_in   (rst_in),
    .start_in (stab_start),
    .done_out (stab_done)
  );

  //--------------------------------------------------------------------
  // Next program counter and condition codes
  //--------------------------------------------------------------------
  always_comb begin
    pc_d = pc_q;
    case (state_q)
      S_VEC_LD: pc_d = {vhi_q, op};
      S_OPND: begin
        if (is_br || is_imm)
          pc_d = pc_q + 16'h0002;
        else if (op == OP_RTI)
          pc_d = sh_pc_q;
        else
          pc_d = pc_q + 16'h0001;
      end
      S_BRANCH: pc_d = take ? pc_q + lpb_sext(op) : pc_q;
      default:  pc_d = pc_q;
    endcase
  end

  always_comb begin
    ccr_d = ccr_q;
    if (reg_wr_in && reg_addr_in == REG_CCR)
      ccr_d = reg_wdata_in[7:0] | CCR_ONES;
    if (opnd) begin
      case (op)
        OP_RTI:  ccr_d = sh_ccr_q;
        OP_CLI:  ccr_d[CCR_I] = 1'b0;
        OP_SEI:  ccr_d[CCR_I] = 1'b1;
        OP_WAIT: ccr_d[CCR_I] = 1'b0;
        OP_STOP: ccr_d[CCR_I] = stop_ok ? 1'b0 : ccr_q[CCR_I];
        default: ccr_d = ccr_d;
      endcase
    end
  end

  //--------------------------------------------------------------------
  // Sequencer
  //--------------------------------------------------------------------
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      state_q <= S_VEC_HI;
    end else if (go_brk || go_irq) begin
      state_q <= S_VEC_HI;
    end else begin
      case (state_q)
        S_VEC_HI: state_q <= S_VEC_LO;
        S_VEC_LO: state_q <= S_VEC_LD;
        S_VEC_LD: state_q <= S_FETCH;
        S_FETCH:  state_q <= S_OPND;
        S_OPND: begin
          if (op == OP_WAIT)
            state_q <= S_WAIT;
          else if (op == OP_STOP && stop_ok)
            state_q <= S_STOP;
          else if (is_br)
            state_q <= S_BRANCH;
          else
            state_q <= S_FETCH;
        end
        S_BRANCH: state_q <= S_FETCH;
        S_WAIT:   state_q <= S_WAIT;
        S_STOP:   state_q <= stab_start ? S_STAB : S_STOP;
        S_STAB:   state_q <= S_STAB;
        default:  state_q <= S_VEC_HI;
      endcase
    end
  end

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      pc_q <= 16'h0000;
    end else begin
      pc_q <= pc_d;
    end
  end

  // Interrupt entry sets the mask; reset also sets it
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      ccr_q <= CCR_RST;
    end else if (go_brk || go_irq) begin
      ccr_q <= ccr_d | (8'h01 << CCR_I);
    end else begin
      ccr_q <= ccr_d;
    end
  end

  // Context for the return; break and interrupt share one level
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      sh_pc_q  <= 16'h0000;
      sh_ccr_q <= CCR_RST;
    end else if (go_brk || go_irq) begin
      sh_pc_q  <= pc_d;
      sh_ccr_q <= ccr_d;
    end
  end

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      vaddr_q <= VEC_RESET;
    end else if (go_brk) begin
      vaddr_q <= ctrl_q[CTRL_MON] ? VEC_BRK_MON : VEC_BRK;
    end else if (go_irq) begin
      vaddr_q <= irq_vec_in;
    end
  end

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      vhi_q <= 8'h00;
    end else if (state_q == S_VEC_LO) begin
      vhi_q <= op;
    end
  end

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      ir_q <= 8'h00;
    end else if (go_brk) begin
      ir_q <= OP_SWI;
    end else if (opnd) begin
      ir_q <= op;
    end
  end

  //--------------------------------------------------------------------
  // Break tracking
  //--------------------------------------------------------------------
  // A request seen mid-instruction is held until the boundary
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      brk_pend_q <= 1'b0;
    end else if (go_brk || brk_act_q) begin
      brk_pend_q <= 1'b0;
    end else if (brk_req_in) begin
      brk_pend_q <= 1'b1;
    end
  end

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      brk_act_q <= 1'b0;
    end else if (go_brk) begin
      brk_act_q <= 1'b1;
    end else if (opnd && op == OP_RTI && !brk_req_in) begin
      brk_act_q <= 1'b0;
    end
  end

  //--------------------------------------------------------------------
  // Immediate adds
  //--------------------------------------------------------------------
  // The immediate arrives one cycle after the operand read, whatever
  // state follows, so the add completes within two cycles
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      xpend_q <= 1'b0;
      xsp_q   <= 1'b0;
    end else begin
      xpend_q <= opnd && is_imm;
      xsp_q   <= op == OP_AIS;
    end
  end

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      sp_q <= SP_RST;
    end else if (xpend_q && xsp_q) begin
      sp_q <= sp_q + lpb_sext(op);
    end
  end

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      hx_q <= HX_RST;
    end else if (xpend_q && !xsp_q) begin
      hx_q <= hx_q + lpb_sext(op);
    end
  end

  //--------------------------------------------------------------------
  // Memory port and status
  //--------------------------------------------------------------------
  always_comb begin
    mem_rd_out   = 1'b0;
    mem_addr_out = pc_q;
    case (state_q)
      S_VEC_HI: begin
        mem_rd_out   = 1'b1;
        mem_addr_out = vaddr_q;
      end
      S_VEC_LO: begin
        mem_rd_out   = 1'b1;
        mem_addr_out = vaddr_q + 16'h0001;
      end
      S_FETCH: mem_rd_out = 1'b1;
      S_OPND: begin
        mem_rd_out   = is_br || is_imm;
        mem_addr_out = pc_q + 16'h0001;
      end
      default: mem_rd_out = 1'b0;
    endcase
  end

  // Clock gate stays off through the stabilisation wait
  assign cpu_clk_en_out = !(state_q == S_WAIT || state_q == S_STOP ||
                            state_q == S_STAB);

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      irq_ack_q <= 1'b0;
    end else begin
      irq_ack_q <= go_irq;
    end
  end

  assign irq_ack_out    = irq_ack_q;
  assign brk_active_out = brk_act_q;

  //--------------------------------------------------------------------
  // Register port
  //--------------------------------------------------------------------
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      ctrl_q <= CTRL_RST;
    end else if (reg_wr_in && reg_addr_in == REG_CTRL) begin
      ctrl_q <= reg_wdata_in[1:0];
    end
  end

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      rdata_q <= 32'h0000_0000;
    end else if (reg_rd_in) begin
      case (reg_addr_in)
        REG_CTRL:   rdata_q <= {30'h0000_0000, ctrl_q};
        REG_STATUS: rdata_q <= {24'h00_0000, ir_q[7:4],
                                cpu_clk_en_out, brk_act_q,
                                state_q == S_STOP || state_q == S_STAB,
                                state_q == S_WAIT};
        REG_CCR:    rdata_q <= {24'h00_0000, ccr_q};
        REG_PC:     rdata_q <= {16'h0000, pc_q};
        REG_SP:     rdata_q <= {16'h0000, sp_q};
        REG_HX:     rdata_q <= {16'h0000, hx_q};
        default:    rdata_q <= 32'h0000_0000;
      endcase
    end else begin
      rdata_q <= 32'h0000_0000;
    end
  end

  assign reg_rdata_out = rdata_q;

  //--------------------------------------------------------------------
  // Checks
  //--------------------------------------------------------------------
  sequence s_br_decode;
    opnd && is_br;
  endsequence

  sequence s_br_done;
    state_q == S_BRANCH ##1 (state_q == S_FETCH || $past(go_brk || go_irq));
  endsequence

  property p_wait_mask;
    @(posedge clock_in) disable iff (rst_in)
      state_q == S_WAIT |-> !ccr_q[CCR_I] && !cpu_clk_en_out;
  endproperty
  a_wait_mask: assert property (p_wait_mask)
    else $error("wait entered with mask set or clock running");

  property p_stop_mask;
    @(posedge clock_in) disable iff (rst_in)
      opnd && op == OP_STOP && stop_ok |=>
        state_q == S_STOP && !ccr_q[CCR_I];
  endproperty
  a_stop_mask: assert property (p_stop_mask)
    else $error("stop did not clear mask and stop clock");

  property p_stab_hold;
    @(posedge clock_in) disable iff (rst_in)
      stab_start |=> (!cpu_clk_en_out && state_q == S_STAB)
        until stab_done;
  endproperty
  a_stab_hold: assert property (p_stab_hold)
    else $error("clock restarted before stabilisation");

  property p_brk_entry;
    @(posedge clock_in) disable iff (rst_in)
      go_brk |=> ir_q == OP_SWI && state_q == S_VEC_HI &&
        mem_addr_out == (ctrl_q[CTRL_MON] ? VEC_BRK_MON : VEC_BRK);
  endproperty
  a_brk_entry: assert property (p_brk_entry)
    else $error("break entry opcode or vector wrong");

  property p_brk_bound;
    @(posedge clock_in) disable iff (rst_in)
      bound && brk_req_in && !brk_act_q |=> brk_act_q;
  endproperty
  a_brk_bound: assert property (p_brk_bound)
    else $error("break not started at instruction end");

  property p_brk_end;
    @(posedge clock_in) disable iff (rst_in)
      brk_act_q && opnd && op == OP_RTI |=>
        brk_act_q == $past(brk_req_in);
  endproperty
  a_brk_end: assert property (p_brk_end)
    else $error("return did not end break correctly");

  property p_br_cycles;
    @(posedge clock_in) disable iff (rst_in)
      s_br_decode and !go_brk |=> s_br_done;
  endproperty
  a_br_cycles: assert property (p_br_cycles)
    else $error("branch did not take three cycles");

  property p_br_target;
    @(posedge clock_in) disable iff (rst_in)
      state_q == S_BRANCH && !go_brk && !go_irq |=>
        pc_q == $past(pc_q) + ($past(take) ? lpb_sext($past(op)) : 16'h0000)
        && ccr_q == $past(ccr_d);
  endproperty
  a_br_target: assert property (p_br_target)
    else $error("branch target or flags wrong");

  property p_ais;
    @(posedge clock_in) disable iff (rst_in)
      opnd && op == OP_AIS |=> ##1 sp_q == $past(sp_q) + lpb_sext($past(op));
  endproperty
  a_ais: assert property (p_ais)
    else $error("stack pointer add wrong");

  property p_aix;
    @(posedge clock_in) disable iff (rst_in)
      opnd && op == OP_AIX |=> ##1 hx_q == $past(hx_q) + lpb_sext($past(op));
  endproperty
  a_aix: assert property (p_aix)
    else $error("index pair add wrong");

  property p_mask;
    @(posedge clock_in) disable iff (rst_in)
      irq_ack_out |-> $past(!ccr_d[CCR_I] || state_q == S_WAIT ||
                            state_q == S_STAB);
  endproperty
  a_mask: assert property (p_mask)
    else $error("interrupt taken while masked");
endmodule : lpb_core

// ### rtl/lpb_pkg.sv
//----------------------------------------------------------------------
// What this block does
// - Wait clears mask, stops clock; reset sets it
// - Stop clears mask, stops clock; reset sets it
// - After stop, clock waits for oscillator delay
// - Break forces interrupt opcode, loads break vector
// - Break starts at instruction end; a request made earlier is held
// - Return ends break once request is gone
// - Carry-clear branch: three cycles, flags untouched
// - Carry-set branch: three cycles, flags untouched
// - Half-carry-clear branch: three cycles, no flag change
// - Half-carry-set branch: three cycles, no flag change
// - Signed greater-equal branch when N xor V zero
// - Signed greater branch when Z or (N xor V) zero
// - Stack pointer adds signed immediate, two cycles
// - Index pair adds signed immediate, two cycles
// - Mask set blocks maskable interrupts; reset sets mask
//----------------------------------------------------------------------
// Purpose: constants, types and decoders of the standby/break core
// Assumes: 200 MHz core clock
// Notes:   register offsets are byte addresses on a 32-bit port
package lpb_pkg;
  localparam int CLK_MHZ     = 200;
  localparam int OSC_STAB_NS = 10000;
  localparam int STAB_CYC    = (OSC_STAB_NS * CLK_MHZ + 999) / 1000;
  localparam int STAB_W      = 12;

  // Opcodes
  localparam logic [7:0] OP_BCC  = 8'h24;
  localparam logic [7:0] OP_BCS  = 8'h25;
  localparam logic [7:0] OP_BRANCH_HALF_CARRY_CLEAR = 8'h28;
  localparam logic [7:0] OP_BRANCH_HALF_CARRY_SET = 8'h29;
  localparam logic [7:0] OP_BGE  = 8'h90;
  localparam logic [7:0] OP_BGT  = 8'h92;
  localparam logic [7:0] OP_AIS  = 8'hA7;
  localparam logic [7:0] OP_AIX  = 8'hAF;
  localparam logic [7:0] OP_SWI  = 8'h83;
  localparam logic [7:0] OP_RTI  = 8'h80;
  localparam logic [7:0] OP_WAIT = 8'h8F;
  localparam logic [7:0] OP_STOP = 8'h8E;
  localparam logic [7:0] OP_CLI  = 8'h9A;
  localparam logic [7:0] OP_SEI  = 8'h9B;

  localparam logic [15:0] VEC_RESET   = 16'hFFFE;
  localparam logic [15:0] VEC_BRK     = 16'hFFFC;
  localparam logic [15:0] VEC_BRK_MON = 16'hFEFC;
  localparam logic [15:0] SP_RST      = 16'h00FF;
  localparam logic [15:0] HX_RST      = 16'h0000;

  // Condition code bit positions
  localparam int CCR_V = 7;
  localparam int CCR_H = 4;
  localparam int CCR_I = 3;
  localparam int CCR_N = 2;
  localparam int CCR_Z = 1;
  localparam int CCR_C = 0;
  localparam logic [7:0] CCR_RST  = 8'h68;
  localparam logic [7:0] CCR_ONES = 8'h60;

  // Register port
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_CCR    = 8'h08;
  localparam logic [7:0] REG_PC     = 8'h0C;
  localparam logic [7:0] REG_SP     = 8'h10;
  localparam logic [7:0] REG_HX     = 8'h14;
  localparam int CTRL_MON    = 0;
  localparam int CTRL_STOPEN = 1;
  localparam logic [1:0] CTRL_RST = 2'h2;

  typedef enum logic [3:0] {
    S_VEC_HI, S_VEC_LO, S_VEC_LD, S_FETCH, S_OPND,
    S_BRANCH, S_WAIT, S_STOP, S_STAB
  } lpb_state_t;

  function automatic logic lpb_is_branch(input logic [7:0] op);
    return op == OP_BCC || op == OP_BCS || op == OP_BRANCH_HALF_CARRY_CLEAR ||
           op == OP_BRANCH_HALF_CARRY_SET || op == OP_BGE || op == OP_BGT;
  endfunction : lpb_is_branch

  function automatic logic [15:0] lpb_sext(input logic [7:0] b);
    return {{8{b[7]}}, b};
  endfunction : lpb_sext
endpackage : lpb_pkg

// ### rtl/lpb_stab_timer.sv
// Purpose: oscillator stabilisation delay after leaving stop
// Assumes: start_in is a one-cycle pulse
// Notes:   done_out is a level held until the next start
`timescale 1ns/1ps
module lpb_stab_timer
  import lpb_pkg::*;
(
  input  wire logic clock_in,
  input  wire logic rst_in,
  input  wire logic start_in,
  output logic      done_out
);
  localparam logic [STAB_W-1:0] LAST = STAB_W'(STAB_CYC - 1);
  logic [STAB_W-1:0] cnt_q;
  logic              run_q;

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      cnt_q <= '0;
      run_q <= 1'b0;
    end else if (start_in) begin
      cnt_q <= '0;
      run_q <= 1'b1;
    end else if (run_q && cnt_q != LAST) begin
      cnt_q <= cnt_q + STAB_W'(1);
    end
  end

  assign done_out = run_q && cnt_q == LAST;
endmodule : lpb_stab_timer

// ### verif/lpb_core_test.sv
// Purpose: self-checking bench of the standby/break/branch core
// Assumes: program and vectors preloaded into the memory partner
// Notes:   outputs sampled at the falling edge, inputs driven at rising
`timescale 1ns/1ps
module lpb_core_test;
  import lpb_pkg::*;
  logic        clock_in = 1'b0;
  logic        rst_in = 1'b1;
  logic        irq_in = 1'b0;
  logic        ext_irq_in = 1'b0;
  logic        brk_req_in = 1'b0;
  logic [7:0]  reg_addr_in = 8'h00;
  logic [31:0] reg_wdata_in = 32'h0000_0000;
  logic        reg_wr_in = 1'b0;
  logic        reg_rd_in = 1'b0;
  logic [7:0]  mem_rdata_in;
  logic [15:0] mem_addr_out;
  logic        mem_rd_out, cpu_clk_en_out, irq_ack_out, brk_active_out;
  logic [31:0] reg_rdata_out, rd_q;
  int          n_fail = 0, n_compared = 0, cyc = 0, n, k;
  lpb_core lpb_core_i (.clock_in(clock_in), .rst_in(rst_in),
    .mem_rdata_in(mem_rdata_in), .irq_in(irq_in), .ext_irq_in(ext_irq_in),
    .irq_vec_in(16'hFFF0), .brk_req_in(brk_req_in),
    .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
    .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .mem_addr_out(mem_addr_out), .mem_rd_out(mem_rd_out),
    .cpu_clk_en_out(cpu_clk_en_out), .irq_ack_out(irq_ack_out),
    .brk_active_out(brk_active_out), .reg_rdata_out(reg_rdata_out));
  lpb_mem_model lpb_mem_model_i (.clock_in(clock_in),
    .addr_in(mem_addr_out), .rd_in(mem_rd_out), .data_out(mem_rdata_in));
  initial begin
    forever #2.5 clock_in = ~clock_in;
  end
  // Run is about 2400 cycles; a hang is cut well past that
  always @(posedge clock_in) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      end_of_test();
    end
  end
  //--------------------------------------------------------------------
  // Bus and compare tasks
  //--------------------------------------------------------------------
  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock_in);
    reg_addr_in  <= a;
    reg_wdata_in <= d;
    reg_wr_in    <= 1'b1;
    @(posedge clock_in);
    reg_wr_in <= 1'b0;
  endtask : reg_wr
  task automatic reg_rd(input logic [7:0] a);
    @(posedge clock_in);
    reg_addr_in <= a;
    reg_rd_in   <= 1'b1;
    @(posedge clock_in);
    reg_rd_in <= 1'b0;
    @(negedge clock_in);
    rd_q = reg_rdata_out;
  endtask : reg_rd
  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_val
  task automatic chk_cyc(input int got, input int exp);
    n_compared++;
    if (got != exp) begin
      n_fail++;
      $display("wrong value at %0t: count %0d not %0d", $time, got, exp);
    end
  endtask : chk_cyc
  // Cycles until a read of address a; -1 when none within lim
  task automatic wait_rd(input logic [15:0] a, input int lim,
                         output int c);
    bit hit;
    hit = 1'b0;
    c = 0;
    while (!hit && c < lim) begin
      @(negedge clock_in);
      c++;
      hit = (mem_rd_out === 1'b1 && mem_addr_out === a);
    end
    if (!hit) c = -1;
  endtask : wait_rd
  task automatic restart(input logic [7:0] condition_code_register, input logic [7:0] p0,
                         input logic [7:0] p1);
    @(posedge clock_in);
    rst_in <= 1'b1;
    lpb_mem_model_i.mem[16'h1000] = p0;
    lpb_mem_model_i.mem[16'h1001] = p1;
    repeat (2) @(posedge clock_in);
    rst_in <= 1'b0;
    if (condition_code_register != 8'h00) reg_wr(REG_CCR, {24'h00_0000, condition_code_register});
  endtask : restart
  //--------------------------------------------------------------------
  // Scenarios
  //--------------------------------------------------------------------
  task automatic t_reset;
    restart(8'h00, 8'h9D, 8'h9D);
    reg_rd(REG_CCR);
    chk_val(rd_q, 32'h0000_0068);
    reg_rd(REG_SP);
    chk_val(rd_q, 32'h0000_00FF);
    reg_rd(REG_HX);
    chk_val(rd_q, 32'h0000_0000);
    reg_rd(8'h40);
    chk_val(rd_q, 32'h0000_0000);
    @(posedge clock_in);
    irq_in <= 1'b1;
    wait_rd(16'hFFF0, 30, n);
    chk_cyc(n, -1);
    @(posedge clock_in);
    irq_in <= 1'b0;
    $display("test reset done");
  endtask : t_reset
  task automatic t_branch;
    logic [7:0] ops [6];
    logic [7:0] ccrs [12];
    ops  = '{OP_BCC, OP_BCS, OP_BRANCH_HALF_CARRY_CLEAR, OP_BRANCH_HALF_CARRY_SET, OP_BGE, OP_BGT};
    ccrs = '{8'h68, 8'h69, 8'h69, 8'h68, 8'h68, 8'h78,
             8'h78, 8'h68, 8'hEC, 8'h6C, 8'hEC, 8'h6A};
    for (int i = 0; i < 12; i++) begin
      restart(ccrs[i], ops[i/2], 8'h10);
      wait_rd(16'h1001, 40, n);
      wait_rd((i % 2) ? 16'h1002 : 16'h1012, 8, n);
      chk_cyc(n, 2);
      reg_rd(REG_CCR);
      chk_val(rd_q, {24'h00_0000, ccrs[i]});
    end
    $display("test branch done");
  endtask : t_branch
  task automatic t_addimm;
    restart(8'h68, OP_AIS, 8'h80);
    wait_rd(16'h1001, 40, n);
    wait_rd(16'h1002, 4, n);
    chk_cyc(n, 1);
    reg_rd(REG_SP);
    chk_val(rd_q, 32'h0000_007F);
    restart(8'h68, OP_AIX, 8'hFF);
    wait_rd(16'h1001, 40, n);
    wait_rd(16'h1002, 4, n);
    chk_cyc(n, 1);
    reg_rd(REG_HX);
    chk_val(rd_q, 32'h0000_FFFF);
    reg_rd(REG_CCR);
    chk_val(rd_q, 32'h0000_0068);
    $display("test add immediate done");
  endtask : t_addimm
  task automatic t_break(input logic mon);
    restart(8'h68, 8'h9D, 8'h9D);
    reg_wr(REG_CTRL, {30'h0000_0000, 1'b1, mon});
    wait_rd(16'h1002, 40, n);
    // Request lands mid-branch, so the vector read waits for its end
    @(posedge clock_in);
    brk_req_in <= 1'b1;
    wait_rd(mon ? VEC_BRK_MON : VEC_BRK, 8, n);
    chk_cyc(n, 3);
    @(posedge clock_in);
    brk_req_in <= 1'b0;
    reg_rd(REG_STATUS);
    chk_val({28'h000_0000, rd_q[7:4]}, 32'h0000_0008);
    chk_val({31'h0000_0000, rd_q[2]}, 32'h0000_0001);
    k = 0;
    while (brk_active_out !== 1'b0 && k < 20) begin
      @(negedge clock_in);
      k++;
    end
    chk_val({31'h0000_0000, brk_active_out}, 32'h0000_0000);
    $display("test break done");
  endtask : t_break
  task automatic t_standby(input logic [7:0] op);
    restart(8'h00, op, 8'h9D);
    wait_rd(16'h1000, 40, n);
    repeat (4) @(negedge clock_in);
    chk_val({31'h0000_0000, cpu_clk_en_out}, 32'h0000_0000);
    reg_rd(REG_CCR);
    chk_val({31'h0000_0000, rd_q[CCR_I]}, 32'h0000_0000);
    @(posedge clock_in);
    irq_in <= 1'b1;
    if (op == OP_STOP) begin
      wait_rd(16'hFFF0, 20, n);
      chk_cyc(n, -1);
      @(posedge clock_in);
      ext_irq_in <= 1'b1;
      k = 0;
      while (cpu_clk_en_out !== 1'b1 && k < 2100) begin
        @(negedge clock_in);
        k++;
      end
      chk_cyc(int'(k >= STAB_CYC && k <= STAB_CYC + 3), 1);
      // Wake read is already on the bus in the cycle the clock restarts
      n = (mem_rd_out === 1'b1 && mem_addr_out === 16'hFFF0) ? 1 : -1;
    end else begin
      wait_rd(16'hFFF0, 10, n);
    end
    chk_cyc(int'(n > 0), 1);
    k = 0;
    while (irq_ack_out !== 1'b1 && k < 4) begin
      @(negedge clock_in);
      k++;
    end
    chk_val({31'h0000_0000, irq_ack_out}, 32'h0000_0001);
    @(posedge clock_in);
    irq_in     <= 1'b0;
    ext_irq_in <= 1'b0;
    wait_rd(16'h3000, 10, n);
    repeat (4) @(negedge clock_in);
    reg_rd(REG_CCR);
    chk_val({31'h0000_0000, rd_q[CCR_I]}, 32'h0000_0000);
    restart(8'h00, op, 8'h9D);
    repeat (10) @(negedge clock_in);
    restart(8'h00, 8'h9D, 8'h9D);
    reg_rd(REG_CCR);
    chk_val(rd_q, 32'h0000_0068);
    $display("test standby done");
  endtask : t_standby
  task automatic end_of_test;
    $display("compared %0d, failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : end_of_test
  initial begin
    for (int a = 0; a < 65536; a++) lpb_mem_model_i.mem[a] = 8'h9D;
    lpb_mem_model_i.mem[16'hFFFE] = 8'h10;
    lpb_mem_model_i.mem[16'hFFFF] = 8'h00;
    lpb_mem_model_i.mem[16'hFFFC] = 8'h20;
    lpb_mem_model_i.mem[16'hFFFD] = 8'h00;
    lpb_mem_model_i.mem[16'hFEFC] = 8'h20;
    lpb_mem_model_i.mem[16'hFEFD] = 8'h00;
    lpb_mem_model_i.mem[16'hFFF0] = 8'h30;
    lpb_mem_model_i.mem[16'hFFF1] = 8'h00;
    lpb_mem_model_i.mem[16'h2000] = OP_RTI;
    lpb_mem_model_i.mem[16'h3000] = OP_RTI;
    lpb_mem_model_i.mem[16'h1002] = OP_BCC;
    lpb_mem_model_i.mem[16'h1003] = 8'h00;
    repeat (10) @(posedge clock_in);
    t_reset();
    t_branch();
    t_addimm();
    t_break(1'b0);
    t_break(1'b1);
    t_standby(OP_WAIT);
    t_standby(OP_STOP);
    end_of_test();
  end
endmodule : lpb_core_test

// ### verif/lpb_mem_model.sv
// Purpose: memory partner answering core reads one cycle later
// Assumes: no wait states; contents loaded by the bench
// Notes:   idle bus shows the inverted last byte, never a stale copy
`timescale 1ns/1ps
module lpb_mem_model (
  input  wire logic        clock_in,
  input  wire logic [15:0] addr_in,
  input  wire logic        rd_in,
  output logic [7:0]       data_out
);
  logic [7:0]  mem [0:65535];
  logic [7:0]  last_q = 8'h00;
  logic        ans_q  = 1'b0;
  logic [15:0] a_q    = 16'h0000;
  always_ff @(posedge clock_in) begin
    ans_q <= rd_in;
    a_q   <= addr_in;
    if (ans_q) last_q <= mem[a_q];
  end
  assign data_out = ans_q ? mem[a_q] : ~last_q;
endmodule : lpb_mem_model
